// ==== rtl/trc_pkg.sv ====
package trc_pkg;
   // bus address bytes, write and read
   localparam logic [7:0] DEV_ADDR_WR = 8'h9E;
   localparam logic [7:0] DEV_ADDR_RD = 8'h9F;
   // command bytes
   localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
   localparam logic [7:0] CMD_ACCESS_CLOCK = 8'hC0;
   localparam logic [7:0] CMD_ACCESS_CONFIG = 8'hAC;
   // clock register pointer: seconds first, year last
   localparam logic [7:0] CLK_REG_MINUTES = 8'h01;
   localparam int CLK_REG_COUNT = 7;
   localparam logic [2:0] CLK_REG_LAST = 3'h6;
   localparam logic [2:0] PTR_FIRST = 3'h0;
   localparam logic [2:0] PTR_STEP = 3'h1;
   // byte framing: eight data bits, then the acknowledge slot
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] BIT_STEP = 4'h1;
   // value returned where nothing is selected
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   // controller timing: 400 kHz bus clock split in four quarters
   localparam int CORE_PERIOD_NS = 10;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);
   // target states
   typedef enum logic [2:0] {T_IDLE, T_ADDR, T_CMD, T_REG, T_DATA, T_TX, T_TX_ACK, T_TX_NEXT}
      trc_tgt_state_type;
   // controller states
   typedef enum logic [3:0] {C_IDLE, C_START, C_ADDRW, C_CMD, C_REG, C_RSTART, C_ADDRR,
      C_READ, C_STOP} trc_ctl_state_type;
endpackage : trc_pkg

// ==== rtl/trc_i2c_if.sv ====
interface trc_i2c_if;
   // resolved wire levels, high when released
   logic scl;
   logic sda;
   // controller pin drive, enable high pulls the wire
   logic ctrlSclOut;
   logic ctrlSclOe;
   logic ctrlSdaOut;
   logic ctrlSdaOe;
   // target data pin drive
   logic tgtSdaOut;
   logic tgtSdaOe;
   // open-drain resolution
   assign scl = ~(ctrlSclOe & ~ctrlSclOut);
   assign sda = ~((ctrlSdaOe & ~ctrlSdaOut) | (tgtSdaOe & ~tgtSdaOut));
   modport target (input scl, input sda, output tgtSdaOut, output tgtSdaOe);
   modport controller (input scl, input sda, output ctrlSclOut, output ctrlSclOe,
      output ctrlSdaOut, output ctrlSdaOe);
endinterface : trc_i2c_if

// ==== rtl/trc_i2c_target.sv ====
module trc_i2c_target (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // bus side
   trc_i2c_if.target bus,
   // values offered for readback
   input wire logic [15:0] tempValue,
   input wire logic [15:0] cfgValue,
   input wire logic [7:0] clkRegs [trc_pkg::CLK_REG_COUNT],
   // received command and write data
   output logic cmdStrobe,
   output logic [7:0] cmdCode,
   output logic wrStrobe,
   output logic [7:0] wrData,
   output logic [2:0] wrPtr,
   output logic busy
);
   // previous wire samples
   logic sclPrev_q;
   logic sdaPrev_q;
   // sequencing state
   trc_pkg::trc_tgt_state_type state_q;
   trc_pkg::trc_tgt_state_type next_q;
   trc_pkg::trc_tgt_state_type nextAfter;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   // pin drive state
   logic ackDrv_q;
   logic txOn_q;
   logic [7:0] txShift_q;
   // command context
   logic [7:0] cmd_q;
   logic [2:0] ptr_q;
   logic [2:0] ptrNext;
   logic [7:0] readByte;
   // bus events
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic rxState;
   logic addrHit;
   logic byteDone;
   logic ackTake;
   logic ackEnd;
   logic txAcked;

   // wire edges and bus conditions
   assign sclRise = bus.scl & ~sclPrev_q;
   assign sclFall = ~bus.scl & sclPrev_q;
   assign startSeen = bus.scl & sclPrev_q & sdaPrev_q & ~bus.sda;
   assign stopSeen = bus.scl & sclPrev_q & ~sdaPrev_q & bus.sda;
   assign rxState = (state_q == trc_pkg::T_ADDR) || (state_q == trc_pkg::T_CMD) ||
      (state_q == trc_pkg::T_REG) || (state_q == trc_pkg::T_DATA);
   // only the two own address bytes match
   assign addrHit = (shift_q == trc_pkg::DEV_ADDR_WR) ||
      (shift_q == trc_pkg::DEV_ADDR_RD);
   assign byteDone = rxState && sclFall && (cnt_q == trc_pkg::ACK_SLOT) && !ackDrv_q;
   assign ackTake = byteDone && ((state_q != trc_pkg::T_ADDR) || addrHit);
   assign ackEnd = rxState && sclFall && ackDrv_q;
   assign txAcked = (state_q == trc_pkg::T_TX_ACK) && sclRise && !bus.sda;

   // open-drain data pin: ack slot or a zero bit pulls low
   assign bus.tgtSdaOut = 1'b0;
   assign bus.tgtSdaOe = ackDrv_q | (txOn_q & ~txShift_q[7]);

   // state after the acknowledge slot of a received byte
   always_comb
   begin
      nextAfter = trc_pkg::T_DATA;
      if (state_q == trc_pkg::T_ADDR)
      begin
         // read address goes straight to transmit
         nextAfter = shift_q[0] ? trc_pkg::T_TX : trc_pkg::T_CMD;
      end
      else if (state_q == trc_pkg::T_CMD && shift_q == trc_pkg::CMD_ACCESS_CLOCK)
      begin
         // clock access takes a pointer byte first
         nextAfter = trc_pkg::T_REG;
      end
   end

   // pointer step: clock walks to year and wraps, pairs toggle
   always_comb
   begin
      if (cmd_q == trc_pkg::CMD_ACCESS_CLOCK)
      begin
         ptrNext = (ptr_q >= trc_pkg::CLK_REG_LAST) ? trc_pkg::PTR_FIRST
            : ptr_q + trc_pkg::PTR_STEP;
      end
      else
      begin
         ptrNext = ptr_q ^ trc_pkg::PTR_STEP;
      end
   end

   // byte offered for the next read slot
   always_comb
   begin
      readByte = trc_pkg::IDLE_BYTE;
      if (cmd_q == trc_pkg::CMD_READ_TEMP)
      begin
         // msb at pointer 0, lsb at pointer 1
         readByte = ptr_q[0] ? tempValue[7:0] : tempValue[15:8];
      end
      else if (cmd_q == trc_pkg::CMD_ACCESS_CONFIG)
      begin
         // upper byte first, flags in lower byte
         readByte = ptr_q[0] ? cfgValue[7:0] : cfgValue[15:8];
      end
      else if (cmd_q == trc_pkg::CMD_ACCESS_CLOCK && ptr_q <= trc_pkg::CLK_REG_LAST)
      begin
         // pointer selects the calendar register
         readByte = clkRegs[ptr_q];
      end
   end

   // wire sampling
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end
      else
      begin
         sclPrev_q <= bus.scl;
         sdaPrev_q <= bus.sda;
      end
   end

   // transaction sequencing
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= trc_pkg::T_IDLE;
         next_q <= trc_pkg::T_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
      end
      else if (startSeen)
      begin
         // start or repeated start: fresh address byte
         state_q <= trc_pkg::T_ADDR;
         cnt_q <= 4'h0;
      end
      else if (stopSeen)
      begin
         // stop closes the exchange
         state_q <= trc_pkg::T_IDLE;
      end
      else if (rxState)
      begin
         if (sclRise && cnt_q != trc_pkg::ACK_SLOT)
         begin
            // shift in one bit, msb first
            shift_q <= {shift_q[6:0], bus.sda};
            cnt_q <= cnt_q + trc_pkg::BIT_STEP;
         end
         if (byteDone)
         begin
            // not our address: sit out until next start
            state_q <= addrHit || state_q != trc_pkg::T_ADDR ? state_q
               : trc_pkg::T_IDLE;
            next_q <= nextAfter;
         end
         if (ackEnd)
         begin
            // acknowledge slot over
            state_q <= next_q;
            cnt_q <= 4'h0;
         end
      end
      else if (state_q == trc_pkg::T_TX)
      begin
         if (sclRise)
         begin
            cnt_q <= cnt_q + trc_pkg::BIT_STEP;
         end
         if (sclFall && cnt_q == trc_pkg::ACK_SLOT)
         begin
            // eight bits out: controller answers
            state_q <= trc_pkg::T_TX_ACK;
         end
      end
      else if (state_q == trc_pkg::T_TX_ACK && sclRise)
      begin
         // ack: another byte, nack: stop sending
         state_q <= bus.sda ? trc_pkg::T_IDLE : trc_pkg::T_TX_NEXT;
      end
      else if (state_q == trc_pkg::T_TX_NEXT && sclFall)
      begin
         state_q <= trc_pkg::T_TX;
         cnt_q <= 4'h0;
      end
   end

   // data pin drive
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ackDrv_q <= 1'b0;
         txOn_q <= 1'b0;
         txShift_q <= 8'h00;
      end
      else if (startSeen || stopSeen)
      begin
         // conditions on the bus free the line
         ackDrv_q <= 1'b0;
         txOn_q <= 1'b0;
      end
      else if (ackTake)
      begin
         ackDrv_q <= 1'b1;
      end
      else if (ackEnd)
      begin
         ackDrv_q <= 1'b0;
         if (next_q == trc_pkg::T_TX)
         begin
            // first read byte goes out right after the address ack
            txOn_q <= 1'b1;
            txShift_q <= readByte;
         end
      end
      else if (state_q == trc_pkg::T_TX && sclFall)
      begin
         if (cnt_q == trc_pkg::ACK_SLOT)
         begin
            // release for the controller's answer
            txOn_q <= 1'b0;
         end
         else
         begin
            txShift_q <= {txShift_q[6:0], 1'b0};
         end
      end
      else if (state_q == trc_pkg::T_TX_NEXT && sclFall)
      begin
         txOn_q <= 1'b1;
         txShift_q <= readByte;
      end
   end

   // command and pointer context, kept across repeated starts
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_q <= 8'h00;
         ptr_q <= trc_pkg::PTR_FIRST;
      end
      else if (byteDone && state_q == trc_pkg::T_CMD)
      begin
         cmd_q <= shift_q;
         ptr_q <= trc_pkg::PTR_FIRST;
      end
      else if (byteDone && state_q == trc_pkg::T_REG)
      begin
         // out-of-range pointer starts at seconds
         ptr_q <= shift_q <= {5'h00, trc_pkg::CLK_REG_LAST} ? shift_q[2:0]
            : trc_pkg::PTR_FIRST;
      end
      else if ((byteDone && state_q == trc_pkg::T_DATA) || txAcked)
      begin
         ptr_q <= ptrNext;
      end
   end

   // user-side strobes
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmdStrobe <= 1'b0;
         wrStrobe <= 1'b0;
         wrData <= 8'h00;
         wrPtr <= trc_pkg::PTR_FIRST;
      end
      else
      begin
         cmdStrobe <= byteDone && state_q == trc_pkg::T_CMD;
         wrStrobe <= byteDone && state_q == trc_pkg::T_DATA;
         if (byteDone && state_q == trc_pkg::T_DATA)
         begin
            wrData <= shift_q;
            wrPtr <= ptr_q;
         end
      end
   end

   assign cmdCode = cmd_q;
   assign busy = (state_q != trc_pkg::T_IDLE);
endmodule : trc_i2c_target

// ==== rtl/trc_i2c_controller.sv ====
module trc_i2c_controller (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // bus side
   trc_i2c_if.controller bus,
   // request port
   input wire logic reqValid,
   output logic reqReady,
   input wire logic [7:0] reqCmd,
   input wire logic reqUseReg,
   input wire logic [7:0] reqRegAddr,
   input wire logic [3:0] reqReadCount,
   // results
   output logic rdValid,
   output logic [7:0] rdData,
   output logic doneStrobe,
   output logic nackSeen
);
   // quarter-bit divider
   logic [15:0] div_q;
   logic tick;
   // sequencing state
   trc_pkg::trc_ctl_state_type state_q;
   logic [1:0] qtr_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic [3:0] remain_q;
   logic ackFail_q;
   logic [7:0] regAddr_q;
   logic useReg_q;
   logic [7:0] cmdByte_q;
   // pin state
   logic sclLow_q;
   logic sdaLow_q;
   // decode
   logic byteState;
   logic isRead;
   logic byteEnd;

   assign tick = (div_q == 16'(trc_pkg::QTR_CYCLES - 1));
   assign byteState = state_q inside {trc_pkg::C_ADDRW, trc_pkg::C_CMD, trc_pkg::C_REG,
      trc_pkg::C_ADDRR, trc_pkg::C_READ};
   assign isRead = (state_q == trc_pkg::C_READ);
   assign byteEnd = tick && byteState && qtr_q == 2'h3 && bit_q == trc_pkg::ACK_SLOT;
   assign reqReady = (state_q == trc_pkg::C_IDLE);
   assign bus.ctrlSclOut = 1'b0;
   assign bus.ctrlSclOe = sclLow_q;
   assign bus.ctrlSdaOut = 1'b0;
   assign bus.ctrlSdaOe = sdaLow_q;

   // quarter-bit tick divider
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         div_q <= 16'h0000;
      else
         div_q <= tick ? 16'h0000 : div_q + 16'h0001;
   end

   // transaction sequencing
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= trc_pkg::C_IDLE;
         qtr_q <= 2'h0;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         remain_q <= 4'h0;
         ackFail_q <= 1'b0;
         regAddr_q <= 8'h00;
         useReg_q <= 1'b0;
         cmdByte_q <= 8'h00;
      end
      else if (state_q == trc_pkg::C_IDLE)
      begin
         // take a request
         if (reqValid)
         begin
            state_q <= trc_pkg::C_START;
            qtr_q <= 2'h0;
            cmdByte_q <= reqCmd;
            useReg_q <= reqUseReg;
            regAddr_q <= reqRegAddr;
            remain_q <= reqReadCount;
         end
      end
      else if (tick)
      begin
         qtr_q <= qtr_q + 2'h1;
         if (qtr_q == 2'h3 && (state_q == trc_pkg::C_START || state_q == trc_pkg::C_RSTART))
         begin
            // address byte follows each start
            state_q <= state_q == trc_pkg::C_START ? trc_pkg::C_ADDRW : trc_pkg::C_ADDRR;
            shift_q <= state_q == trc_pkg::C_START ? trc_pkg::DEV_ADDR_WR
               : trc_pkg::DEV_ADDR_RD;
            bit_q <= 4'h0;
         end
         else if (qtr_q == 2'h3 && state_q == trc_pkg::C_STOP)
         begin
            state_q <= trc_pkg::C_IDLE;
         end
         else if (byteState && qtr_q == 2'h2)
         begin
            // sample data bit or the target's answer
            if (isRead && bit_q != trc_pkg::ACK_SLOT)
               shift_q <= {shift_q[6:0], bus.sda};
            if (!isRead && bit_q == trc_pkg::ACK_SLOT)
               ackFail_q <= bus.sda;
         end
         else if (byteState && qtr_q == 2'h3 && bit_q != trc_pkg::ACK_SLOT)
         begin
            if (!isRead)
               shift_q <= {shift_q[6:0], 1'b0};
            bit_q <= bit_q + trc_pkg::BIT_STEP;
         end
         else if (byteEnd)
         begin
            // choose what follows this byte
            bit_q <= 4'h0;
            if (!isRead && ackFail_q)
               state_q <= trc_pkg::C_STOP;
            else if (state_q == trc_pkg::C_ADDRW)
            begin
               state_q <= trc_pkg::C_CMD;
               shift_q <= cmdByte_q;
            end
            else if (state_q == trc_pkg::C_CMD && useReg_q)
            begin
               state_q <= trc_pkg::C_REG;
               shift_q <= regAddr_q;
            end
            else if (state_q == trc_pkg::C_ADDRR)
               state_q <= trc_pkg::C_READ;
            else if (isRead)
            begin
               remain_q <= remain_q - 4'h1;
               state_q <= remain_q == 4'h1 ? trc_pkg::C_STOP : trc_pkg::C_READ;
            end
            else
               state_q <= remain_q != 4'h0 ? trc_pkg::C_RSTART : trc_pkg::C_STOP;
         end
      end
   end

   // pin drive per quarter
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclLow_q <= 1'b0;
         sdaLow_q <= 1'b0;
      end
      else if (tick && state_q != trc_pkg::C_IDLE)
      begin
         if (state_q == trc_pkg::C_START || state_q == trc_pkg::C_RSTART)
         begin
            // release, raise clock, pull data, pull clock
            unique case (qtr_q)
               2'h0: sdaLow_q <= 1'b0;
               2'h1: sclLow_q <= 1'b0;
               2'h2: sdaLow_q <= 1'b1;
               2'h3: sclLow_q <= 1'b1;
            endcase
         end
         else if (state_q == trc_pkg::C_STOP)
         begin
            // data low under low clock, raise clock, release data
            unique case (qtr_q)
               2'h0: sdaLow_q <= 1'b1;
               2'h1: sclLow_q <= 1'b0;
               2'h2: sdaLow_q <= 1'b0;
               2'h3: sclLow_q <= 1'b0;
            endcase
         end
         else if (qtr_q == 2'h0)
         begin
            // set data while clock is low
            if (bit_q == trc_pkg::ACK_SLOT)
               sdaLow_q <= isRead && remain_q != 4'h1;
            else
               sdaLow_q <= !isRead && !shift_q[7];
         end
         else
            sclLow_q <= (qtr_q == 2'h3);
      end
   end

   // user results
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdValid <= 1'b0;
         rdData <= 8'h00;
         doneStrobe <= 1'b0;
         nackSeen <= 1'b0;
      end
      else
      begin
         rdValid <= byteEnd && isRead;
         if (byteEnd && isRead)
            rdData <= shift_q;
         nackSeen <= byteEnd && !isRead && ackFail_q;
         doneStrobe <= tick && state_q == trc_pkg::C_STOP && qtr_q == 2'h3;
      end
   end
endmodule : trc_i2c_controller

// ==== verification/trc_i2c_properties.sv ====
module trc_i2c_properties (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // resolved wire levels
   input wire logic scl,
   input wire logic sda,
   // pin drives of both ends
   input wire logic ctrlSclOut,
   input wire logic ctrlSclOe,
   input wire logic ctrlSdaOut,
   input wire logic ctrlSdaOe,
   input wire logic tgtSdaOut,
   input wire logic tgtSdaOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   // wire levels one clock back
   logic sclPrev_q;
   logic sdaPrev_q;
   // frame tracking
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q;
   logic first_q;
   logic addrOk_q;
   logic read_q;
   // decoded bus events
   logic riseEv;
   logic fallEv;
   logic startEv;
   logic stopEv;
   logic ackSlot;
   logic ownAddr;
   assign riseEv = ~sclPrev_q & scl;
   assign fallEv = sclPrev_q & ~scl;
   assign startEv = sclPrev_q & scl & sdaPrev_q & ~sda;
   assign stopEv = sclPrev_q & scl & ~sdaPrev_q & sda;
   assign ackSlot = riseEv & (bitCnt_q == 4'h8);
   assign ownAddr = (shift_q[7:1] == 7'h4F);
   // released wires after reset
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end
      else
      begin
         sclPrev_q <= scl;
         sdaPrev_q <= sda;
      end
   end
   // bit count, address match and direction of the current frame
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         first_q <= 1'b0;
         addrOk_q <= 1'b0;
         read_q <= 1'b0;
      end
      else if (startEv)
      begin
         bitCnt_q <= 4'h0;
         first_q <= 1'b1;
         addrOk_q <= 1'b0;
         read_q <= 1'b0;
      end
      else if (stopEv)
      begin
         first_q <= 1'b0;
         addrOk_q <= 1'b0;
         read_q <= 1'b0;
      end
      else if (ackSlot)
      begin
         bitCnt_q <= 4'h0;
         first_q <= 1'b0;
         // address byte decides match and direction
         if (first_q)
         begin
            addrOk_q <= ownAddr & ~sda;
            read_q <= ownAddr & ~sda & shift_q[0];
         end
         // nack ends the read burst
         else if (read_q && sda)
            read_q <= 1'b0;
      end
      else if (riseEv)
      begin
         bitCnt_q <= bitCnt_q + 4'h1;
         shift_q <= {shift_q[6:0], sda};
      end
   end
   open_drain_only_a: assert property (!tgtSdaOut && !ctrlSdaOut && !ctrlSclOut)
      else $error("a pin drives high");
   // outside an addressed frame the target leaves the data line alone
   quiet_unaddressed_a: assert property (first_q || addrOk_q || !tgtSdaOe)
      else $error("target drives while not addressed");
   addr_ack_due_a: assert property ((fallEv && bitCnt_q == 4'h8 && first_q && ownAddr)
      |-> ##[1:6] tgtSdaOe)
      else $error("address ack late");
   addr_acked_a: assert property ((ackSlot && first_q && ownAddr) |-> !sda)
      else $error("own address not acknowledged");
   byte_acked_a: assert property ((ackSlot && addrOk_q && !read_q && !first_q)
      |-> !sda)
      else $error("written byte not acknowledged");
   read_line_free_a: assert property ((riseEv && read_q && bitCnt_q != 4'h8)
      |-> !ctrlSdaOe)
      else $error("controller drives during read data");
   ack_slot_free_a: assert property ((ackSlot && read_q) |-> !tgtSdaOe)
      else $error("target drives in controller ack slot");
   nack_release_a: assert property ((ackSlot && read_q && sda) |=> (!tgtSdaOe) [*8])
      else $error("target drives after nack");
   data_low_phase_a: assert property ($changed(tgtSdaOe) |-> !scl)
      else $error("target data moves while clock high");
   stop_idle_a: assert property (stopEv |-> (!tgtSdaOe) [*8])
      else $error("target drives after stop");
   // main scenarios
   cover property (ackSlot && read_q && sda);
   cover property (startEv && addrOk_q);
   cover property (stopEv);
endmodule : trc_i2c_properties

// ==== verification/thermo_rtc_i2c_command_port_bench.sv ====
module thermo_rtc_i2c_command_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset and shared bus
   logic core_clk;
   logic rst_b;
   trc_i2c_if bus ();
   // controller request and results
   logic reqValid;
   logic reqReady;
   logic [7:0] reqCmd;
   logic reqUseReg;
   logic [7:0] reqRegAddr;
   logic [3:0] reqReadCount;
   logic rdValid;
   logic [7:0] rdData;
   logic doneStrobe;
   logic nackSeen;
   // target readback values and status
   logic [15:0] tempValue;
   logic [15:0] cfgValue;
   logic [7:0] clkRegs [trc_pkg::CLK_REG_COUNT];
   logic cmdStrobe;
   logic [7:0] cmdCode;
   logic busy;
   logic wrStrobe;
   // expectation notes: read bytes, commands, wire bytes with ack bit
   logic [7:0] rdExpQ [$];
   logic [7:0] cmdExpQ [$];
   logic [8:0] wireExpQ [$];
   logic [8:0] wireShift;
   int wireBits;
   int mismatches;
   int testsRun;
   trc_i2c_target i_trc_i2c_target (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
      .tempValue(tempValue), .cfgValue(cfgValue), .clkRegs(clkRegs), .cmdStrobe(cmdStrobe),
      .cmdCode(cmdCode), .wrStrobe(wrStrobe), .wrData(), .wrPtr(), .busy(busy));
   trc_i2c_controller i_trc_i2c_controller (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
      .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqUseReg(reqUseReg),
      .reqRegAddr(reqRegAddr), .reqReadCount(reqReadCount), .rdValid(rdValid),
      .rdData(rdData), .doneStrobe(doneStrobe), .nackSeen(nackSeen));
   trc_i2c_properties i_trc_i2c_properties (.core_clk(core_clk), .rst_b(rst_b),
      .scl(bus.scl), .sda(bus.sda), .ctrlSclOut(bus.ctrlSclOut), .ctrlSclOe(bus.ctrlSclOe),
      .ctrlSdaOut(bus.ctrlSdaOut), .ctrlSdaOe(bus.ctrlSdaOe), .tgtSdaOut(bus.tgtSdaOut),
      .tgtSdaOe(bus.tgtSdaOe));
   // byte compare
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp8
   // wire byte plus ack bit compare
   task automatic cmp9(input logic [8:0] got, input logic [8:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t wire %h exp %h", $time, got, exp);
      end
   endtask : cmp9
   // verdict and end of run
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // notes a one- or two-byte read exchange, then runs it to doneStrobe
   task automatic read_two(input logic [7:0] cmd, input logic usePtr, input logic [7:0] ptr,
         input logic [7:0] d0, input logic [7:0] d1, input logic single);
      wireExpQ.push_back({8'h9E, 1'b0});
      wireExpQ.push_back({cmd, 1'b0});
      if (usePtr)
         wireExpQ.push_back({ptr, 1'b0});
      wireExpQ.push_back({8'h9F, 1'b0});
      // the last byte read is not acknowledged
      wireExpQ.push_back({d0, single});
      cmdExpQ.push_back(cmd);
      rdExpQ.push_back(d0);
      if (!single)
      begin
         wireExpQ.push_back({d1, 1'b1});
         rdExpQ.push_back(d1);
      end
      reqCmd <= cmd;
      reqUseReg <= usePtr;
      reqRegAddr <= ptr;
      reqReadCount <= single ? 4'h1 : 4'h2;
      reqValid <= 1'b1;
      // hold the request until taken while ready
      do
         @(posedge core_clk);
      while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      // a hang is caught by the watchdog
      while (doneStrobe !== 1'b1)
         @(posedge core_clk);
      cmp8({7'h00, busy}, 8'h00);
   endtask : read_two
   // free-running clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // result watcher: oldest note against each result
   always @(posedge core_clk)
   begin
      if (rdValid === 1'b1)
         cmp8(rdData, (rdExpQ.size() > 0) ? rdExpQ.pop_front() : 8'hXX);
      if (cmdStrobe === 1'b1)
         cmp8(cmdCode, (cmdExpQ.size() > 0) ? cmdExpQ.pop_front() : 8'hXX);
      if (nackSeen !== 1'b0)
         cmp8({7'h00, nackSeen}, 8'h00);
      // these exchanges carry no data byte to write
      if (wrStrobe !== 1'b0)
         cmp8({7'h00, wrStrobe}, 8'h00);
   end
   // wire sniffer: start clears the bit count
   always @(negedge bus.sda)
   begin
      if (bus.scl === 1'b1)
         wireBits = 0;
   end
   // wire sniffer: eight data bits then the ack bit
   always @(posedge bus.scl)
   begin
      wireShift = {wireShift[7:0], bus.sda};
      wireBits++;
      if (wireBits == 9)
      begin
         wireBits = 0;
         cmp9(wireShift, (wireExpQ.size() > 0) ? wireExpQ.pop_front()
            : 9'h1XX);
      end
   end
   // watchdog sized from the planned 768 bus quarters plus margin
   initial
   begin
      repeat (1000 * trc_pkg::QTR_CYCLES) @(posedge core_clk);
      mismatches++;
      $display("[FAIL] t=%0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
      report_and_stop();
   end
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      reqValid = 1'b0;
      reqCmd = 8'h00;
      reqUseReg = 1'b0;
      reqRegAddr = 8'h00;
      reqReadCount = 4'h0;
      tempValue = 16'h0000;
      cfgValue = 16'h0000;
      foreach (clkRegs[i])
         clkRegs[i] = 8'h00;
      wireShift = 9'h000;
      wireBits = 0;
      mismatches = 0;
      testsRun = 0;
      void'($urandom(32'h2DCEECAB));
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      tempValue <= 16'($urandom());
      cfgValue <= 16'($urandom());
      foreach (clkRegs[i])
         clkRegs[i] <= 8'($urandom());
      @(posedge core_clk);
      cmp8({6'h00, reqReady, busy}, 8'h02);
      cmp8(cmdCode, 8'h00);
      // temperature, msb then lsb
      read_two(8'hAA, 1'b0, 8'h00, tempValue[15:8], tempValue[7:0], 1'b0);
      @(posedge core_clk);
      // clock pointer at minutes, then hours with mode bit
      read_two(8'hC0, 1'b1, 8'h01, clkRegs[1], clkRegs[2], 1'b0);
      @(posedge core_clk);
      // configuration, upper byte then flags byte
      read_two(8'hAC, 1'b0, 8'h00, cfgValue[15:8], cfgValue[7:0], 1'b0);
      @(posedge core_clk);
      // temperature msb only, then nack and stop
      read_two(8'hAA, 1'b0, 8'h00, tempValue[15:8], 8'h00, 1'b1);
      @(posedge core_clk);
      cmp8(8'(rdExpQ.size() + cmdExpQ.size() + wireExpQ.size()), 8'h00);
      report_and_stop();
   end
endmodule : thermo_rtc_i2c_command_port_bench
